// ---- rtl/ssw_pkg.sv ----
// Types shared by the supply supervisor
package ssw_pkg;

  typedef enum logic {
    SSW_HOLD = 1'b0,
    SSW_RUN  = 1'b1
  } ssw_state_t;

  typedef enum logic [1:0] {
    SSW_STB_LOW   = 2'b00,
    SSW_STB_HIGH  = 2'b01,
    SSW_STB_FLOAT = 2'b10
  } ssw_strobe_t;

endpackage

// ---- rtl/ssw_regs.svh ----
// Register offsets, field positions, reset values and timing constants of the supply supervisor
`ifndef SSW_REGS_SVH
`define SSW_REGS_SVH

`define SSW_CLK_KHZ          40000
`define SSW_RST_SHORT_MS     50
`define SSW_RST_LONG_MS      200
`define SSW_RST_SHORT_MIN_MS 35
`define SSW_RST_LONG_MIN_MS  140
`define SSW_WD_LONG_MS       1600
`define SSW_WD_SHORT_MS      100

`define SSW_EXT_DIV          64
`define SSW_EXT_DIV_LAST     6'h3f
`define SSW_EXT_RST_CLKS     1024
`define SSW_EXT_WD_LONG_CLKS 65536
`define SSW_EXT_WD_CLKS      4096

`define SSW_OFF_CTRL         8'h00
`define SSW_OFF_STATUS       8'h04
`define SSW_OFF_WD_COUNT     8'h08
`define SSW_OFF_RST_COUNT    8'h0c

`define SSW_CTRL_WD_ALLOW    0
`define SSW_CTRL_LONG_VAR    1
`define SSW_CTRL_RESET       2'h1

`define SSW_ST_RESET_N       0
`define SSW_ST_SUPPLY_OK     1
`define SSW_ST_FAULT_N       2
`define SSW_ST_PF_FLAG_N     3
`define SSW_ST_BACKUP        4
`define SSW_ST_OSC_INT       5
`define SSW_ST_WD_LONG       6

`define SSW_RESP_OKAY        2'h0
`define SSW_RESP_SLVERR      2'h2

`endif

// ---- rtl/ssw_top.sv ----
// Supply supervisor: timed reset, watchdog, chip-select gating, power-fail flag, AXI4-Lite registers
// Functional notes
// - Reset output low while supply is low or main supply is below backup.
// - Reset held at least 35ms short variant, 140ms long variant after recovery.
// - Unserviced enabled watchdog issues one full reset pulse per timeout period.
// - Active-high reset output is always the inverse of active-low reset.
// - Supply-low indication follows the threshold comparator with no stretching.
// - Supply-low indication also low while main supply is below backup.
// - Floating strobe disables the watchdog; host floats it to keep watchdog off.
// - Strobe constant beyond timeout drives reset and watchdog fault low.
// - Every strobe transition restarts the timer; host toggles within each period.
// - Fault output returns high on strobe transition or supply-low indication falling.
// - Chip-select follows input while supply good, forced high otherwise.
// - Select high uses internal oscillator; low uses oscillator pin timing.
// - External clock divided by 64 before it clocks the watchdog timer.
// - External mode reset time and timeout are fixed external clock counts.
// - Internal mode reset time nominal 50ms short, 200ms long variant.
// - Internal mode oscillator pin level picks 1.6s or 100ms timeout.
// - First watchdog timeout after any reset is the long period: 1.6s internal, 65536 external clocks.
// - Backup-active low on main supply, high when switched to backup.
// - Backup switch comparator hysteresis decides which supply feeds memory.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ssw_regs.svh"

module ssw_top #(
  parameter int RST_SHORT_CYC = `SSW_RST_SHORT_MS * `SSW_CLK_KHZ,
  parameter int RST_LONG_CYC  = `SSW_RST_LONG_MS * `SSW_CLK_KHZ,
  parameter int WD_LONG_CYC   = `SSW_WD_LONG_MS * `SSW_CLK_KHZ,
  parameter int WD_SHORT_CYC  = `SSW_WD_SHORT_MS * `SSW_CLK_KHZ
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        supply_threshold_cmp,
  input  wire logic        backup_switch_cmp,
  input  wire logic        powerfail_cmp,
  input  wire logic [1:0]  watchdog_strobe_in,
  input  wire logic        osc_source_sel,
  input  wire logic        osc_pin,
  input  wire logic        ce_in_n,
  output logic             reset_n,
  output logic             reset_hi,
  output logic             supply_low_n,
  output logic             watchdog_fault_n,
  output logic             powerfail_flag_n,
  output logic             backup_active,
  output logic             ce_out_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [31:0] pick(input logic sel, input int a, input int b);
    pick = sel ? 32'(a) : 32'(b);
  endfunction

  // Core state
  ssw_pkg::ssw_state_t state_ff;
  ssw_pkg::ssw_state_t nxt_state;
  logic [31:0]         rst_cnt_ff;
  logic [31:0]         nxt_rst_cnt;
  logic [31:0]         wd_cnt_ff;
  logic [31:0]         nxt_wd_cnt;
  logic [1:0]          stb_ff;
  logic                wd_long_ff;
  logic                nxt_wd_long;
  logic                fault_n_ff;
  logic                nxt_fault_n;
  logic                osc_prev_ff;
  logic [5:0]          div_ff;
  logic [5:0]          nxt_div;
  logic                reset_n_ff;
  logic                supply_low_n_ff;
  logic                pf_flag_n_ff;
  logic                backup_ff;
  logic                ce_out_n_ff;
  logic [1:0]          ctrl_ff;
  logic [1:0]          nxt_ctrl;

  logic        osc_rise;
  logic        tick;
  logic        supply_bad;
  logic        stb_float;
  logic        trans;
  logic        wd_en;
  logic        expire;
  logic        cause;
  logic        lowline_fall;
  logic [31:0] rst_lim;
  logic [31:0] wd_lim;

  always_comb
  begin
    // Comparator outputs are already synchronous; no extra sync stage
    supply_bad = supply_threshold_cmp | backup_switch_cmp;
    stb_float  = (watchdog_strobe_in != ssw_pkg::SSW_STB_LOW) &&
                 (watchdog_strobe_in != ssw_pkg::SSW_STB_HIGH);
    osc_rise   = osc_pin & ~osc_prev_ff;
    // Divided external clock gives one tick per 64 edges; phase error is tolerated
    tick       = osc_source_sel ? 1'b1 : (osc_rise && (div_ff == `SSW_EXT_DIV_LAST));
    nxt_div    = (!osc_source_sel && osc_rise) ? 6'(div_ff + 6'h1) : div_ff;
    // Internal limits in clk_sys cycles, external ones in divided ticks
    rst_lim    = osc_source_sel ? pick(ctrl_ff[`SSW_CTRL_LONG_VAR], RST_LONG_CYC, RST_SHORT_CYC)
                                : pick(1'b1, `SSW_EXT_RST_CLKS / `SSW_EXT_DIV, 0);
    if (osc_source_sel)
      wd_lim = pick(wd_long_ff || osc_pin, WD_LONG_CYC, WD_SHORT_CYC);
    else
      wd_lim = pick(wd_long_ff, `SSW_EXT_WD_LONG_CLKS / `SSW_EXT_DIV,
                    `SSW_EXT_WD_CLKS / `SSW_EXT_DIV);
    trans      = (watchdog_strobe_in != stb_ff);
    wd_en      = ctrl_ff[`SSW_CTRL_WD_ALLOW] && !stb_float && (state_ff == ssw_pkg::SSW_RUN);
    expire     = wd_en && !trans && tick && ((wd_cnt_ff + 32'h1) >= wd_lim);
    cause      = supply_bad | expire;
    lowline_fall = supply_bad & supply_low_n_ff;
  end

  always_comb
  begin
    nxt_state   = state_ff;
    nxt_rst_cnt = rst_cnt_ff;
    case (state_ff)
      ssw_pkg::SSW_HOLD:
      begin
        if (cause)
          nxt_rst_cnt = 32'h0;
        else if (tick)
        begin
          if ((rst_cnt_ff + 32'h1) >= rst_lim)
          begin
            nxt_state   = ssw_pkg::SSW_RUN;
            nxt_rst_cnt = 32'h0;
          end
          else
            nxt_rst_cnt = rst_cnt_ff + 32'h1;
        end
      end
      ssw_pkg::SSW_RUN:
      begin
        if (cause)
        begin
          nxt_state   = ssw_pkg::SSW_HOLD;
          nxt_rst_cnt = 32'h0;
        end
      end
      default:
      begin
        nxt_state   = ssw_pkg::SSW_HOLD;
        nxt_rst_cnt = 32'h0;
      end
    endcase
  end

  always_comb
  begin
    nxt_wd_cnt  = wd_cnt_ff;
    nxt_wd_long = wd_long_ff;
    nxt_fault_n = fault_n_ff;
    if (!wd_en || trans || expire)
      nxt_wd_cnt = 32'h0;
    else if (tick)
      nxt_wd_cnt = wd_cnt_ff + 32'h1;
    if (nxt_state == ssw_pkg::SSW_HOLD)
      nxt_wd_long = 1'b1;
    else if (trans && (state_ff == ssw_pkg::SSW_RUN))
      nxt_wd_long = 1'b0;
    if (expire)
      nxt_fault_n = 1'b0;
    // Recovery wins over a same-cycle timeout so no service is lost
    if (trans || lowline_fall)
      nxt_fault_n = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_ff        <= ssw_pkg::SSW_HOLD;
      rst_cnt_ff      <= 32'h0;
      wd_cnt_ff       <= 32'h0;
      stb_ff          <= ssw_pkg::SSW_STB_FLOAT;
      wd_long_ff      <= 1'b1;
      fault_n_ff      <= 1'b1;
      osc_prev_ff     <= 1'b0;
      div_ff          <= 6'h0;
      reset_n_ff      <= 1'b0;
      supply_low_n_ff <= 1'b0;
      pf_flag_n_ff    <= 1'b0;
      backup_ff       <= 1'b0;
      ce_out_n_ff     <= 1'b1;
    end
    else if (clk_en)
    begin
      state_ff        <= nxt_state;
      rst_cnt_ff      <= nxt_rst_cnt;
      wd_cnt_ff       <= nxt_wd_cnt;
      stb_ff          <= watchdog_strobe_in;
      wd_long_ff      <= nxt_wd_long;
      fault_n_ff      <= nxt_fault_n;
      osc_prev_ff     <= osc_pin;
      div_ff          <= nxt_div;
      reset_n_ff      <= (nxt_state == ssw_pkg::SSW_RUN);
      supply_low_n_ff <= ~supply_bad;
      pf_flag_n_ff    <= powerfail_cmp & ~backup_switch_cmp;
      backup_ff       <= backup_switch_cmp;
      ce_out_n_ff     <= ce_in_n | supply_bad;
    end
  end

  assign reset_n          = reset_n_ff;
  assign reset_hi         = ~reset_n_ff;
  assign supply_low_n     = supply_low_n_ff;
  assign watchdog_fault_n = fault_n_ff;
  assign powerfail_flag_n = pf_flag_n_ff;
  assign backup_active    = backup_ff;
  assign ce_out_n         = ce_out_n_ff;

  // AXI4-Lite slave; one write and one read in flight, frozen with the rest when clk_en is low
  logic        aw_got_ff;
  logic        nxt_aw_got;
  logic [7:0]  aw_addr_ff;
  logic [7:0]  nxt_aw_addr;
  logic        w_got_ff;
  logic        nxt_w_got;
  logic [31:0] w_data_ff;
  logic [31:0] nxt_w_data;
  logic        w_strb0_ff;
  logic        nxt_w_strb0;
  logic        bvalid_ff;
  logic        nxt_bvalid;
  logic [1:0]  bresp_ff;
  logic [1:0]  nxt_bresp;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0]  rresp_ff;
  logic [1:0]  nxt_rresp;
  logic [31:0] status_word;

  always_comb
  begin
    status_word = 32'h0;
    status_word[`SSW_ST_RESET_N]   = reset_n_ff;
    status_word[`SSW_ST_SUPPLY_OK] = supply_low_n_ff;
    status_word[`SSW_ST_FAULT_N]   = fault_n_ff;
    status_word[`SSW_ST_PF_FLAG_N] = pf_flag_n_ff;
    status_word[`SSW_ST_BACKUP]    = backup_ff;
    status_word[`SSW_ST_OSC_INT]   = osc_source_sel;
    status_word[`SSW_ST_WD_LONG]   = wd_long_ff;
  end

  assign s_axi_awready = clk_en && !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = clk_en && !w_got_ff && !bvalid_ff;
  assign s_axi_arready = clk_en && !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb
  begin
    nxt_aw_got  = aw_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_got   = w_got_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb0 = w_strb0_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_ctrl    = ctrl_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw_got  = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w_got   = 1'b1;
      nxt_w_data  = s_axi_wdata;
      nxt_w_strb0 = s_axi_wstrb[0];
    end
    if (aw_got_ff && w_got_ff && !bvalid_ff)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got  = 1'b0;
      nxt_bvalid = 1'b1;
      // Only the control word is writable; the others answer with an error
      if (aw_addr_ff == `SSW_OFF_CTRL)
      begin
        nxt_bresp = `SSW_RESP_OKAY;
        if (w_strb0_ff)
          nxt_ctrl = w_data_ff[1:0];
      end
      else
        nxt_bresp = `SSW_RESP_SLVERR;
    end
    else if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `SSW_RESP_OKAY;
      case (s_axi_araddr)
        `SSW_OFF_CTRL:      nxt_rdata = {30'h0, ctrl_ff};
        `SSW_OFF_STATUS:    nxt_rdata = status_word;
        `SSW_OFF_WD_COUNT:  nxt_rdata = wd_cnt_ff;
        `SSW_OFF_RST_COUNT: nxt_rdata = rst_cnt_ff;
        default:
        begin
          nxt_rdata = 32'h0;
          nxt_rresp = `SSW_RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 8'h0;
      w_got_ff   <= 1'b0;
      w_data_ff  <= 32'h0;
      w_strb0_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      ctrl_ff    <= `SSW_CTRL_RESET;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0;
      rresp_ff   <= 2'h0;
    end
    else if (clk_en)
    begin
      aw_got_ff  <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff   <= nxt_w_got;
      w_data_ff  <= nxt_w_data;
      w_strb0_ff <= nxt_w_strb0;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      ctrl_ff    <= nxt_ctrl;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  reset_inverse_a: assert property (reset_hi == !reset_n) else $error("reset polarity pair broken");
  cause_reset_a: assert property (clk_en && supply_bad |=> !reset_n && !supply_low_n && ce_out_n)
    else $error("supply fault did not force outputs");
  lowline_track_a: assert property (clk_en && !supply_bad |=> supply_low_n) else $error("supply-low stretched");
  ce_follow_a: assert property (clk_en && !supply_bad |=> ce_out_n == $past(ce_in_n))
    else $error("chip select not following");
  pf_batt_a: assert property (clk_en |=> powerfail_flag_n == ($past(powerfail_cmp) && !backup_active))
    else $error("power-fail or backup flag wrong");
  hold_length_a: assert property ($rose(reset_n) |-> ($past(rst_cnt_ff) + 32'h1) == $past(rst_lim))
    else $error("reset released at wrong count");
  hold_min_a: assert property ($rose(reset_n) && osc_source_sel |-> ($past(rst_cnt_ff) + 32'h1) >=
    pick(ctrl_ff[`SSW_CTRL_LONG_VAR], `SSW_RST_LONG_MIN_MS * RST_LONG_CYC / `SSW_RST_LONG_MS,
    `SSW_RST_SHORT_MIN_MS * RST_SHORT_CYC / `SSW_RST_SHORT_MS)) else $error("reset time below minimum");
  cnt_restart_a: assert property (clk_en && cause |=> rst_cnt_ff == 32'h0) else $error("reset count kept");
  wd_float_a: assert property (clk_en && stb_float |=> wd_cnt_ff == 32'h0) else $error("watchdog ran while floating");
  wd_service_a: assert property (clk_en && trans |=> wd_cnt_ff == 32'h0 && watchdog_fault_n)
    else $error("transition did not service watchdog");
  wd_fire_a: assert property (clk_en && expire |=> !watchdog_fault_n && !reset_n ##1 !reset_n)
    else $error("timeout without fault and reset");
  first_long_a: assert property ($rose(reset_n) |-> wd_long_ff) else $error("first timeout not long");
  ext_div_a: assert property (!osc_source_sel && tick |-> osc_rise && div_ff == `SSW_EXT_DIV_LAST)
    else $error("external tick not divided");

  wd_fire_c: cover property (expire ##1 !watchdog_fault_n);
  release_c: cover property ($rose(reset_n));
  ext_tick_c: cover property (!osc_source_sel && tick);
  fault_clear_c: cover property (!watchdog_fault_n ##1 watchdog_fault_n);

endmodule // ssw_top

// ---- sim/ssw_host_model.sv ----
// Host-side model: services the watchdog strobe or leaves it floating
`timescale 1ns/1ps

module ssw_host_model #(
  parameter int SERVICE_CYC = 10
) (
  input  wire logic       clk_sys,
  input  wire logic       service_en,
  input  wire logic       float_req,
  output logic      [1:0] watchdog_strobe_in = 2'h2
);
  int unsigned gap_ff = 0;

  // Period kept well inside the short timeout so jitter never trips a fault
  always @(posedge clk_sys)
  begin
    gap_ff <= (gap_ff == SERVICE_CYC - 1) ? 0 : gap_ff + 1;
    if (float_req)
      watchdog_strobe_in <= ssw_pkg::SSW_STB_FLOAT;
    else if (watchdog_strobe_in == ssw_pkg::SSW_STB_FLOAT)
      watchdog_strobe_in <= ssw_pkg::SSW_STB_LOW;
    else if (service_en && gap_ff == 0)
      watchdog_strobe_in <= watchdog_strobe_in ^ 2'h1;
  end
endmodule // ssw_host_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`include "ssw_regs.svh"

module tb_top;
  // Shortened counts keep the run small; expectations derive from these
  localparam int RS = 20;
  localparam int RL = 80;
  localparam int WL = 200;
  localparam int WS = 50;
  logic        clk_sys, nrst, clk_en, supply_threshold_cmp, backup_switch_cmp, powerfail_cmp;
  logic        osc_source_sel, osc_pin, ce_in_n, reset_n, reset_hi, supply_low_n, watchdog_fault_n;
  logic        powerfail_flag_n, backup_active, ce_out_n, service_en, float_req, ext_run;
  logic [1:0]  watchdog_strobe_in, last_stb, s_axi_bresp, s_axi_rresp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          err_total, check_count, quiet, n;

  ssw_top #(.RST_SHORT_CYC(RS), .RST_LONG_CYC(RL), .WD_LONG_CYC(WL), .WD_SHORT_CYC(WS)) i_ssw_top (
    .clk_sys, .nrst, .clk_en, .supply_threshold_cmp, .backup_switch_cmp, .powerfail_cmp,
    .watchdog_strobe_in, .osc_source_sel, .osc_pin, .ce_in_n, .reset_n, .reset_hi, .supply_low_n,
    .watchdog_fault_n, .powerfail_flag_n, .backup_active, .ce_out_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  ssw_host_model #(.SERVICE_CYC(10)) i_ssw_host_model (.clk_sys, .service_en, .float_req, .watchdog_strobe_in);

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Quiet counts edges since the strobe last moved; osc_pin runs at half clk_sys
  always @(posedge clk_sys)
  begin
    last_stb <= watchdog_strobe_in;
    quiet    <= (watchdog_strobe_in !== last_stb) ? 0 : quiet + 1;
    if (ext_run)
      osc_pin <= ~osc_pin;
  end

  always @(negedge clk_sys)
    if (nrst)
      chk(reset_hi, ~reset_n, "reset_hi");

  task automatic fail(input string m);
    err_total++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk(input logic got, input logic exp, input string m);
    check_count++;
    if (got !== exp)
      fail(m);
  endtask

  task automatic chkw(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
      fail($sformatf("%s %h", m, got));
  endtask

  task automatic chkr(input int v, input int lo, input int hi, input string m);
    check_count++;
    if (v < lo || v > hi)
      fail($sformatf("%s %0d", m, v));
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic wait_out(input bit fault, input logic v, output int k);
    k = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    while (((fault ? watchdog_fault_n : reset_n) !== v) && k < 5000);
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    r = 2'h3;
    while (r === 2'h3)
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    chkw({30'h0, r}, {30'h0, er}, "bresp");
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input logic [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    r = 2'h3;
    d = '1;
    while (r === 2'h3)
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    chkw(d & m, e, "rdata");
    chkw({30'h0, r}, {30'h0, er}, "rresp");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #(20000 * 25);
    fail("timeout");
    conclude();
  end

  initial
  begin
    {nrst, supply_threshold_cmp, backup_switch_cmp, service_en, ext_run, err_total, check_count} = '0;
    {clk_en, powerfail_cmp, osc_source_sel, osc_pin, ce_in_n, float_req} = '1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, quiet} = '0;
    s_axi_wstrb = 4'hf;
    last_stb = 2'h2;
    tick(3);
    nrst <= 1'b1;
    wait_out(0, 1'b1, n);
    chkr(n, RS, RS + 3, "release hold");
    tick(WL + 20);
    #1;
    chk(watchdog_fault_n, 1'b1, "float fault");
    chk(reset_n, 1'b1, "float reset");
    $display("test release done");
    rd_chk(`SSW_OFF_CTRL, 32'h1, `SSW_RESP_OKAY, '1);
    rd_chk(`SSW_OFF_STATUS, 32'h2f, `SSW_RESP_OKAY, 32'h3f);
    rd_chk(8'h10, 32'h0, `SSW_RESP_SLVERR, '1);
    wr_chk(`SSW_OFF_STATUS, 32'h0, `SSW_RESP_SLVERR);
    wr_chk(`SSW_OFF_CTRL, 32'h3, `SSW_RESP_OKAY);
    rd_chk(`SSW_OFF_CTRL, 32'h3, `SSW_RESP_OKAY, '1);
    $display("test registers done");
    ce_in_n <= 1'b0;
    tick(2);
    #1;
    chk(ce_out_n, 1'b0, "ce follow");
    tick(1);
    supply_threshold_cmp <= 1'b1;
    tick(2);
    #1;
    chk(reset_n, 1'b0, "low reset");
    chk(supply_low_n, 1'b0, "low flag");
    chk(ce_out_n, 1'b1, "ce gated");
    tick(1);
    supply_threshold_cmp <= 1'b0;
    tick(2);
    #1;
    chk(supply_low_n, 1'b1, "flag stretch");
    chk(ce_out_n, 1'b0, "ce back");
    chk(reset_n, 1'b0, "hold");
    tick(RL / 2);
    supply_threshold_cmp <= 1'b1;
    tick(1);
    supply_threshold_cmp <= 1'b0;
    wait_out(0, 1'b1, n);
    chkr(n, RL, RL + 3, "long hold");
    wr_chk(`SSW_OFF_CTRL, 32'h1, `SSW_RESP_OKAY);
    $display("test supply done");
    backup_switch_cmp <= 1'b1;
    tick(2);
    #1;
    chk(reset_n, 1'b0, "bk reset");
    chk(supply_low_n, 1'b0, "bk flag");
    chk(powerfail_flag_n, 1'b0, "bk pf");
    chk(backup_active, 1'b1, "bk on");
    chk(ce_out_n, 1'b1, "bk ce");
    tick(1);
    backup_switch_cmp <= 1'b0;
    tick(2);
    #1;
    chk(backup_active, 1'b0, "bk off");
    chk(powerfail_flag_n, 1'b1, "pf high");
    chk(supply_low_n, 1'b1, "bk flag off");
    tick(1);
    powerfail_cmp <= 1'b0;
    tick(2);
    #1;
    chk(powerfail_flag_n, 1'b0, "pf low");
    tick(1);
    powerfail_cmp <= 1'b1;
    ce_in_n <= 1'b1;
    wait_out(0, 1'b1, n);
    tick(1);
    supply_threshold_cmp <= 1'b1;
    tick(1);
    supply_threshold_cmp <= 1'b0;
    clk_en <= 1'b0;
    tick(30);
    clk_en <= 1'b1;
    wait_out(0, 1'b1, n);
    chkr(n, RS - 1, RS + 3, "frozen hold");
    $display("test backup done");
    tick(1);
    osc_pin <= 1'b0;
    float_req <= 1'b0;
    service_en <= 1'b1;
    tick(400);
    #1;
    chk(watchdog_fault_n, 1'b1, "serviced");
    chk(reset_n, 1'b1, "serviced reset");
    tick(1);
    service_en <= 1'b0;
    wait_out(1, 1'b0, n);
    chkr(quiet, WS - 1, WS + 3, "short timeout");
    chk(reset_n, 1'b0, "timeout reset");
    wait_out(0, 1'b1, n);
    chkr(n, RS - 1, RS + 3, "wd pulse");
    wait_out(0, 1'b0, n);
    chkr(n, WL - 1, WL + 3, "first after reset");
    wait_out(0, 1'b1, n);
    tick(1);
    osc_pin <= 1'b1;
    service_en <= 1'b1;
    tick(12);
    #1;
    chk(watchdog_fault_n, 1'b1, "fault cleared");
    tick(1);
    service_en <= 1'b0;
    wait_out(1, 1'b0, n);
    chkr(quiet, WL - 1, WL + 3, "long timeout");
    tick(1);
    supply_threshold_cmp <= 1'b1;
    tick(2);
    #1;
    chk(watchdog_fault_n, 1'b1, "fault on low");
    tick(1);
    supply_threshold_cmp <= 1'b0;
    float_req <= 1'b1;
    wait_out(0, 1'b1, n);
    $display("test watchdog done");
    tick(1);
    osc_source_sel <= 1'b0;
    ext_run <= 1'b1;
    rd_chk(`SSW_OFF_STATUS, 32'h0, `SSW_RESP_OKAY, 32'h20);
    supply_threshold_cmp <= 1'b1;
    tick(2);
    supply_threshold_cmp <= 1'b0;
    wait_out(0, 1'b1, n);
    chkr(n / 2, `SSW_EXT_RST_CLKS - `SSW_EXT_DIV - 1, `SSW_EXT_RST_CLKS + `SSW_EXT_DIV + 1, "ext hold");
    $display("test external done");
    conclude();
  end
endmodule // tb_top
